// ---- rtl/deadband_delay.sv ----
// Dead-band delay for one output: delays rising edge only
// Assumes tick_i pulses once per instruction cycle
`default_nettype none
module deadband_delay (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Control
  input  wire logic       run_i,
  input  wire logic       tick_i,
  input  wire logic [6:0] count_i,
  // Signal
  input  wire logic       raw_i,
  output logic            del_o
);
  logic [6:0] cnt_r, cnt_nxt;
  logic       del_r, del_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    del_nxt = del_r;
    if (run_i) begin
      if (!raw_i) begin
        cnt_nxt = 7'h00;
        del_nxt = 1'b0;
      end else if (!del_r) begin
        if (cnt_r >= count_i) begin
          del_nxt = 1'b1;
        end else if (tick_i) begin
          cnt_nxt = cnt_r + 7'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 7'h00;
      del_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      del_r <= del_nxt;
    end
  end

  // Falling edge passes straight through, no extra lag
  assign del_o = del_r && raw_i;
endmodule : deadband_delay
`default_nettype wire

// ---- rtl/pwm_cfg.svh ----
// Register offsets, field positions, reset values and timing counts
// Assumes a 32-bit classic Wishbone slave, byte addresses, word aligned
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH

`define ADR_PERIOD_LIMIT   4'h0
`define ADR_PERIOD_TIMER   4'h1
`define ADR_DUTY_HIGH      4'h2
`define ADR_DUTY_SHADOW    4'h3
`define ADR_MODULE_CTRL    4'h4
`define ADR_TIMER_CTRL     4'h5
`define ADR_BRIDGE_CTRL    4'h6
`define ADR_FLAGS          4'h7
`define ADR_PIN_DIR        4'h8

`define PERIOD_LIMIT_RST   8'hff
`define PIN_DIR_RST        2'h3
`define DUTY_LSB_LO        4
`define BRIDGE_MODE_HI     7
`define TIMER_ON_BIT       2
`define SLEEP_BIT          3
`define CYC_PER_INSTR      2'h3

`endif

// ---- rtl/pwm_half_bridge.sv ----
// Enhanced PWM with double-buffered 10-bit duty and half-bridge output
// Assumes a classic Wishbone master; pins are resolved outside
`include "pwm_cfg.svh"
`default_nettype none
module pwm_half_bridge (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [5:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  output logic             err_o,
  // PWM pins
  output logic             output_a_o,
  output logic             output_a_oe_o,
  output logic             output_b_complement_o,
  output logic             output_b_complement_oe_o,
  // Status
  output logic             period_flag_o
);
  logic [7:0]  period_limit_r, period_limit_nxt;
  logic [7:0]  period_timer_r, period_timer_nxt;
  logic [7:0]  duty_high_byte_r, duty_high_byte_nxt;
  logic [7:0]  duty_shadow_r, duty_shadow_nxt;
  logic [1:0]  duty_latch_r, duty_latch_nxt;
  logic [7:0]  module_control_r, module_control_nxt;
  logic [7:0]  timer_ctrl_r, timer_ctrl_nxt;
  logic [7:0]  bridge_control_r, bridge_control_nxt;
  logic [1:0]  pin_direction_r, pin_direction_nxt;
  logic        period_flag_r, period_flag_nxt;
  logic [3:0]  pre_r, pre_nxt;
  logic [1:0]  osc_r, osc_nxt;
  logic        pwm_r, pwm_nxt;
  logic        ack_r, ack_nxt;
  logic        err_r, err_nxt;
  logic [31:0] dat_r, dat_nxt;
  pwm_pkg::gen_state_t state_r, state_nxt;

  logic        req;
  logic        wr;
  logic [3:0]  widx;
  logic        pwm_mode;
  logic        sleep;
  logic        run;
  logic        incr;
  logic        match;
  logic [1:0]  low_bits;
  logic [9:0]  time_base;
  logic [9:0]  duty_buf;
  logic [9:0]  duty_new;
  logic        instr_tick;
  logic        half;
  logic        raw_b;
  logic        dly_a;
  logic        dly_b;
  logic        act_a;
  logic        act_b;
  logic        inv_a;
  logic        inv_b;
  logic        clr_now;
  logic        pwm_live;
  pwm_pkg::prescale_t pre_sel;

  assign req      = cyc_i && stb_i && !ack_r && !err_r;
  // Writes land at the edge where the master sees ack, never earlier
  assign wr       = cyc_i && stb_i && ack_r && we_i && sel_i[0];
  assign widx     = adr_i[5:2];
  // PWM modes are 11xx in the output mode bits
  assign pwm_mode = module_control_r[3:2] == 2'h3;
  assign sleep    = timer_ctrl_r[`SLEEP_BIT];
  assign run      = timer_ctrl_r[`TIMER_ON_BIT] && !sleep;
  assign pre_sel  = pwm_pkg::prescale_t'(timer_ctrl_r[1:0]);
  assign half     = module_control_r[`BRIDGE_MODE_HI:6] == pwm_pkg::BR_HALF;

  // One timer increment per 4 x prescale clocks
  always_comb begin
    case (pre_sel)
      pwm_pkg::PRE_1:  incr = osc_r == `CYC_PER_INSTR;
      pwm_pkg::PRE_4:  incr = osc_r == `CYC_PER_INSTR && pre_r[1:0] == 2'h3;
      pwm_pkg::PRE_16: incr = osc_r == `CYC_PER_INSTR && pre_r == 4'hf;
      default:         incr = osc_r == `CYC_PER_INSTR && pre_r == 4'hf; // 11 acts as 16
    endcase
  end

  // Low time-base bits come from clock phase or prescaler
  always_comb begin
    case (pre_sel)
      pwm_pkg::PRE_1: low_bits = osc_r;
      pwm_pkg::PRE_4: low_bits = pre_r[1:0];
      default:        low_bits = pre_r[3:2];
    endcase
  end

  assign instr_tick = run && osc_r == `CYC_PER_INSTR;
  assign match      = period_timer_r == period_limit_r;
  assign time_base  = {period_timer_r, low_bits};
  assign duty_buf   = {duty_shadow_r, duty_latch_r};
  assign duty_new   = {duty_high_byte_r, module_control_r[`DUTY_LSB_LO+1:`DUTY_LSB_LO]};

  // Timer, duty buffer and waveform
  always_comb begin
    period_timer_nxt = period_timer_r;
    duty_shadow_nxt  = duty_shadow_r;
    duty_latch_nxt   = duty_latch_r;
    pre_nxt          = pre_r;
    osc_nxt          = osc_r;
    pwm_nxt          = pwm_r;
    state_nxt        = state_r;
    period_flag_nxt  = period_flag_r;
    if (run) begin
      osc_nxt = osc_r + 2'h1;
      if (osc_r == `CYC_PER_INSTR) begin
        pre_nxt = pre_r + 4'h1;
      end
      if (incr) begin
        pre_nxt = 4'h0;
        if (match) begin
          period_timer_nxt = 8'h00;
          duty_shadow_nxt  = duty_new[9:2];
          duty_latch_nxt   = duty_new[1:0];
          period_flag_nxt  = 1'b1;
          if (pwm_mode) begin
            state_nxt = pwm_pkg::GEN_RUN;
            pwm_nxt   = duty_new != 10'h000;
          end
        end else begin
          period_timer_nxt = period_timer_r + 8'h01;
        end
      end
      // Compare only against the latched value; duty past period never hits
      if (state_r == pwm_pkg::GEN_RUN && time_base == duty_buf) begin
        pwm_nxt = 1'b0;
      end
    end
    if (!pwm_mode) begin
      state_nxt = pwm_pkg::GEN_WAIT;
      pwm_nxt   = 1'b0;
    end
    if (wr && widx == `ADR_PERIOD_TIMER) begin
      period_timer_nxt = dat_i[7:0];
    end
    if (wr && widx == `ADR_DUTY_SHADOW && !pwm_mode) begin
      duty_shadow_nxt = dat_i[7:0];
    end
    // Software clear loses to a same-cycle period event
    if (wr && widx == `ADR_FLAGS && dat_i[0] && !(run && incr && match)) begin
      period_flag_nxt = 1'b0;
    end
  end

  // Register file writes
  always_comb begin
    period_limit_nxt   = period_limit_r;
    duty_high_byte_nxt = duty_high_byte_r;
    module_control_nxt = module_control_r;
    timer_ctrl_nxt     = timer_ctrl_r;
    bridge_control_nxt = bridge_control_r;
    pin_direction_nxt  = pin_direction_r;
    if (wr) begin
      case (widx)
        `ADR_PERIOD_LIMIT: period_limit_nxt   = dat_i[7:0];
        `ADR_DUTY_HIGH:    duty_high_byte_nxt = dat_i[7:0];
        `ADR_MODULE_CTRL:  module_control_nxt = dat_i[7:0];
        `ADR_TIMER_CTRL:   timer_ctrl_nxt     = {4'h0, dat_i[3:0]};
        `ADR_BRIDGE_CTRL:  bridge_control_nxt = {1'b0, dat_i[6:0]};
        `ADR_PIN_DIR:      pin_direction_nxt  = dat_i[1:0];
        default:           period_limit_nxt   = period_limit_r;
      endcase
    end
  end

  // Bus answer: one wait-free ack, err for unmapped words
  always_comb begin
    ack_nxt = 1'b0;
    err_nxt = 1'b0;
    dat_nxt = dat_r;
    if (req) begin
      ack_nxt = widx <= `ADR_PIN_DIR;
      err_nxt = widx > `ADR_PIN_DIR;
      case (widx)
        `ADR_PERIOD_LIMIT: dat_nxt = {24'h0, period_limit_r};
        `ADR_PERIOD_TIMER: dat_nxt = {24'h0, period_timer_r};
        `ADR_DUTY_HIGH:    dat_nxt = {24'h0, duty_high_byte_r};
        `ADR_DUTY_SHADOW:  dat_nxt = {24'h0, duty_shadow_r};
        `ADR_MODULE_CTRL:  dat_nxt = {24'h0, module_control_r[7:6], 1'b0,
                                      module_control_r[4:0]};
        `ADR_TIMER_CTRL:   dat_nxt = {24'h0, timer_ctrl_r};
        `ADR_BRIDGE_CTRL:  dat_nxt = {24'h0, bridge_control_r};
        `ADR_FLAGS:        dat_nxt = {31'h0, period_flag_r};
        `ADR_PIN_DIR:      dat_nxt = {30'h0, pin_direction_r};
        default:           dat_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_limit_r   <= `PERIOD_LIMIT_RST;
      period_timer_r   <= 8'h00;
      duty_high_byte_r <= 8'h00;
      duty_shadow_r    <= 8'h00;
      duty_latch_r     <= 2'h0;
      module_control_r <= 8'h00;
      timer_ctrl_r     <= 8'h00;
      bridge_control_r <= 8'h00;
      pin_direction_r  <= `PIN_DIR_RST;
      period_flag_r    <= 1'b0;
      pre_r            <= 4'h0;
      osc_r            <= 2'h0;
      pwm_r            <= 1'b0;
      state_r          <= pwm_pkg::GEN_WAIT;
      ack_r            <= 1'b0;
      err_r            <= 1'b0;
      dat_r            <= 32'h0;
    end else begin
      period_limit_r   <= period_limit_nxt;
      period_timer_r   <= period_timer_nxt;
      duty_high_byte_r <= duty_high_byte_nxt;
      duty_shadow_r    <= duty_shadow_nxt;
      duty_latch_r     <= duty_latch_nxt;
      module_control_r <= module_control_nxt;
      timer_ctrl_r     <= timer_ctrl_nxt;
      bridge_control_r <= bridge_control_nxt;
      pin_direction_r  <= pin_direction_nxt;
      period_flag_r    <= period_flag_nxt;
      pre_r            <= pre_nxt;
      osc_r            <= osc_nxt;
      pwm_r            <= pwm_nxt;
      state_r          <= state_nxt;
      ack_r            <= ack_nxt;
      err_r            <= err_nxt;
      dat_r            <= dat_nxt;
    end
  end

  // Mask in the match cycle so the pulse is exactly duty units wide
  assign clr_now  = state_r == pwm_pkg::GEN_RUN && time_base == duty_buf;
  assign pwm_live = pwm_r && !clr_now;
  // Complement only exists while the generator runs
  assign raw_b = state_r == pwm_pkg::GEN_RUN && !pwm_live;

  deadband_delay u_dly_a (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (run),
    .tick_i  (instr_tick),
    .count_i (bridge_control_r[6:0]),
    .raw_i   (pwm_live),
    .del_o   (dly_a)
  );

  deadband_delay u_dly_b (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (run),
    .tick_i  (instr_tick),
    .count_i (bridge_control_r[6:0]),
    .raw_i   (raw_b),
    .del_o   (dly_b)
  );

  // Dead band applies in half-bridge only
  assign act_a = half ? dly_a : pwm_live;
  assign act_b = half ? dly_b : pwm_live;
  // Mode 1100 all high, 1101 B low, 1110 A low, 1111 all low
  assign inv_a = module_control_r[1];
  assign inv_b = module_control_r[0];
  assign output_a_o            = act_a ^ inv_a;
  assign output_b_complement_o = act_b ^ inv_b;
  // Whole control register zero releases both pins to port function
  assign output_a_oe_o            = pwm_mode && !pin_direction_r[0];
  assign output_b_complement_oe_o = pwm_mode && !pin_direction_r[1];

  assign dat_o         = dat_r;
  assign ack_o         = ack_r;
  assign err_o         = err_r;
  assign period_flag_o = period_flag_r;
endmodule : pwm_half_bridge
`default_nettype wire

// ---- rtl/pwm_pkg.sv ----
// Types shared by the PWM block
// Assumes pwm_cfg.svh supplies the numeric constants
`default_nettype none
package pwm_pkg;
  typedef enum logic [1:0] {
    PRE_1  = 2'h0,
    PRE_4  = 2'h1,
    PRE_16 = 2'h2
  } prescale_t;

  typedef enum logic [1:0] {
    BR_SINGLE = 2'h0,
    BR_HALF   = 2'h2
  } bridge_t;

  typedef enum logic [0:0] {
    GEN_WAIT = 1'h0,
    GEN_RUN  = 1'h1
  } gen_state_t;
endpackage : pwm_pkg
`default_nettype wire

// ---- testbench/power_stage_model.sv ----
// Pair of power switches hanging on the two PWM pins
// Assumes active-high switch inputs and pull-downs on both pins
`default_nettype none
module power_stage_model (
  // Pins from the PWM block
  input  wire logic clk_i,
  input  wire logic a_i,
  input  wire logic a_oe_i,
  input  wire logic b_i,
  input  wire logic b_oe_i,
  // Levels seen by the switches
  output logic      a_line_o,
  output logic      b_line_o,
  output var int    shoot_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released pin falls to its pull-down, so the switch stays off
  assign a_line_o = a_oe_i ? a_i : 1'b0;
  assign b_line_o = b_oe_i ? b_i : 1'b0;
  initial shoot_o = 0;
  // Both switches on at once shorts the supply
  always @(posedge clk_i) begin
    if (a_line_o && b_line_o) shoot_o <= shoot_o + 1;
  end
endmodule : power_stage_model
`default_nettype wire

// ---- testbench/pwm_half_bridge_sva.sv ----
// Bus and pin assertions on the PWM block's top ports
// Assumes one clock and a synchronous active-high reset
`default_nettype none
module pwm_half_bridge_chk (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // Bus
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic [5:0] adr_i,
  input wire logic       ack_o,
  input wire logic       err_o,
  // Pins and status
  input wire logic       output_a_oe_o,
  input wire logic       output_b_complement_oe_o,
  input wire logic       period_flag_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic req;
  assign req = cyc_i && stb_i && !ack_o && !err_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_mapped: assert property (req && adr_i[5:2] <= 4'h8 |=> ack_o && !err_o)
    else $error("mapped access not acked");
  a_err_unmapped: assert property (req && adr_i[5:2] > 4'h8 |=> err_o && !ack_o)
    else $error("unmapped access not refused");
  a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack too long");
  a_ack_has_req: assert property ((ack_o || err_o) |-> $past(cyc_i && stb_i))
    else $error("answer without request");
  a_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && !err_o && !period_flag_o
    && !output_a_oe_o && !output_b_complement_oe_o) else $error("not idle after reset");
  a_oe_a_write: assert property ($changed(output_a_oe_o) |-> $past(ack_o) || $past(rst_i))
    else $error("pin a drive changed without write");
  a_oe_b_write: assert property ($changed(output_b_complement_oe_o) |-> $past(ack_o))
    else $error("pin b drive changed without write");
  a_flag_clear: assert property ($fell(period_flag_o) |-> $past(ack_o) || $past(rst_i))
    else $error("flag cleared without write");
  c_err: cover property (req && adr_i[5:2] > 4'h8);
  c_flag: cover property ($rose(period_flag_o));
  c_drive: cover property ($rose(output_a_oe_o));
endmodule : pwm_half_bridge_chk
bind pwm_half_bridge pwm_half_bridge_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .adr_i(adr_i), .ack_o(ack_o), .err_o(err_o),
  .output_a_oe_o(output_a_oe_o), .period_flag_o(period_flag_o),
  .output_b_complement_oe_o(output_b_complement_oe_o));
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench: register access and pin timing of the PWM block
// Assumes 100 MHz clock; period limit 3 gives 16-clock periods with prescale 1
`include "pwm_cfg.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [5:0]  adr_i = 6'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o, err_o, a_o, a_oe, b_o, b_oe, flag_o, a_l, b_l;
  int          mismatches = 0;
  int          comparisons = 0;
  int          shoot, hi, per, k;
  logic [31:0] q1, q2;
  logic        e1;
  pwm_half_bridge u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .err_o(err_o), .output_a_o(a_o), .output_a_oe_o(a_oe),
    .output_b_complement_o(b_o), .output_b_complement_oe_o(b_oe), .period_flag_o(flag_o));
  power_stage_model u_load (.clk_i(clk_i), .a_i(a_o), .a_oe_i(a_oe), .b_i(b_o),
    .b_oe_i(b_oe), .a_line_o(a_l), .b_line_o(b_l), .shoot_o(shoot));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : ck
  task automatic wb(input logic w, input logic [3:0] idx, input logic [7:0] d,
                    output logic [31:0] q, output logic e);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'h0};
    sel_i <= 4'h1;
    dat_i <= {24'h0, d};
    @(posedge clk_i);
    // Wait for ack or err; only the watchdog ends a wait that gets no answer
    while (ack_o !== 1'b1 && err_o !== 1'b1) @(posedge clk_i);
    q = dat_o;
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    wb(1'b1, idx, d, q, e);
  endtask : wr
  task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    logic        e;
    wb(1'b0, idx, 8'h00, q, e);
    ck(32'(e), 32'(idx > 4'h8));
    if (idx <= 4'h8) ck(q, {24'h0, exp});
  endtask : rd
  // Bounded run length of one resolved pin level
  task automatic run_len(input logic b, input logic v, output int n);
    n = 0;
    while ((b ? b_l : a_l) === v && n < 3000) begin
      n++;
      @(posedge clk_i);
    end
  endtask : run_len
  task automatic meas(input logic b);
    int n;
    @(posedge clk_i);
    run_len(b, 1'b1, n);
    run_len(b, 1'b0, n);
    run_len(b, 1'b1, hi);
    run_len(b, 1'b0, n);
    per = hi + n;
  endtask : meas
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  initial begin
    #300_000;
    mismatches++;
    $display("ERROR %0t watchdog expired", $time);
    stop_test();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(4'h0, `PERIOD_LIMIT_RST);
    rd(4'h8, 8'(`PIN_DIR_RST));
    rd(4'h4, 8'h00);
    rd(4'h9, 8'h00);
    wr(4'h0, 8'h03);
    wr(4'h4, 8'h0c);
    wr(4'h2, 8'h02);
    wr(4'h7, 8'h01);
    wr(4'h5, 8'h04);
    k = 0;
    while (flag_o !== 1'b1 && k < 100) begin
      ck(32'(a_o), 32'h0);
      @(posedge clk_i);
      k++;
    end
    ck(32'(flag_o), 32'h1);
    wr(4'h8, 8'h00);
    ck(32'(a_oe), 32'h1);
    wr(4'h3, 8'h55);
    rd(4'h3, 8'h02);
    for (int i = 0; i < 3; i++) begin
      wr(4'h5, 8'h04 | 8'(i));
      meas(1'b0);
      meas(1'b0);
      ck(32'(per), 32'd16 << (2 * i));
      ck(32'(hi), 32'd8 << (2 * i));
    end
    // Timer held so no period end can latch the new duty yet
    wr(4'h5, 8'h00);
    wr(4'h4, 8'h1c);
    wr(4'h2, 8'h01);
    rd(4'h3, 8'h02);
    wr(4'h5, 8'h04);
    meas(1'b0);
    ck(32'(hi), 32'd5);
    wr(4'h5, 8'h05);
    meas(1'b0);
    meas(1'b0);
    ck(32'(hi), 32'd20);
    wr(4'h5, 8'h04);
    wr(4'h2, 8'hff);
    repeat (40) @(posedge clk_i);
    run_len(1'b0, 1'b1, k);
    ck(32'(k), 32'd3000);
    wr(4'h4, 8'h0e);
    wr(4'h2, 8'h01);
    meas(1'b0);
    meas(1'b0);
    ck(32'(hi), 32'd12);
    // Sleep must freeze the timer and hold the pin level
    wr(4'h5, 8'h0c);
    wb(1'b0, 4'h1, 8'h00, q1, e1);
    k = a_l;
    repeat (50) @(posedge clk_i);
    wb(1'b0, 4'h1, 8'h00, q2, e1);
    ck(q2, q1);
    ck(32'(a_l), 32'(k));
    wr(4'h5, 8'h04);
    wr(4'h4, 8'h8c);
    wr(4'h2, 8'h02);
    wr(4'h6, 8'h01);
    k = shoot;
    meas(1'b0);
    meas(1'b0);
    ck(32'(hi inside {3, 4}), 32'h1);
    meas(1'b1);
    ck(32'(hi inside {3, 4}), 32'h1);
    ck(32'(per), 32'd16);
    ck(32'(shoot - k), 32'h0);
    wr(4'h6, 8'h7f);
    repeat (40) @(posedge clk_i);
    run_len(1'b0, 1'b0, k);
    ck(32'(k), 32'd3000);
    wr(4'h4, 8'h00);
    ck(32'({a_oe, b_oe}), 32'h0);
    stop_test();
  end
endmodule : tb
`default_nettype wire
